// file: hdl/timer16_value_regs.sv
// 16-bit timer value, capture and compare registers behind byte access with a shared
// high-byte latch, plus capture and compare-B interrupt masking.
// Assumes byte accesses synchronous to clk; count_tick is a one-cycle timer clock enable.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RL1: Low byte at base, high at base+1
// RL2: One shared 8-bit high-byte latch
// RL3: Low read latches high; high write precedes
// RL4: Counter value readable and writable
// RL5: Counter write blocks next tick's match
// RL6: Software avoids changing running counter
// RL7: Capture event copies counter into capture
// RL8: Capture register can serve as TOP
// RL9: Both compares checked every timer tick
// RL10: Match raises flag and drives output; compare A match here only toggles its output, no flag
// RL11: Counter, capture, compares reset to zero
// RL12: Mask bit 5 gates capture interrupt
// RL13: Mask bit 2 gates compare-B interrupt
// RL14: Capture flag clears on service or one
// RL15: Capture-as-TOP disconnects capture input
// RL16: Edge select: 0 falling, 1 rising
module timer16_value_regs (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	input  wire logic       count_tick,
	input  wire logic       capture_input_pin,
	input  wire logic       comparator_out,
	input  wire logic       capture_from_comparator,
	input  wire logic       capture_edge_select,
	input  wire logic       capture_is_top,
	input  wire logic       global_irq_enable,
	input  wire logic       capture_irq_ack,
	input  wire logic       compare_b_irq_ack,
	input  wire logic       capture_flag_clear,
	input  wire logic       compare_b_flag_clear,
	output logic            capture_flag,
	output logic            compare_b_flag,
	output logic            capture_irq,
	output logic            compare_b_irq,
	output logic            compare_a_output,
	output logic            compare_b_output,
	output logic     [15:0] top_value
);
	logic [15:0] counter_value_reg;
	logic [15:0] capture_value_reg;
	logic [15:0] compare_a_value_reg;
	logic [15:0] compare_b_value_reg;
	logic [7:0]  temp_reg;
	logic [7:0]  irq_mask_reg;
	logic        block_match_reg;
	logic        cap_src_prev_reg;
	logic        cap_armed_reg;
	logic        cap_src;
	logic        cap_event;
	logic        match_a;
	logic        match_b;
	logic [16:0] count_next;

	// Register addresses, high byte one above the low byte
	logic wr_cnt_lo, wr_cnt_hi, wr_cap_lo, wr_cap_hi;
	logic wr_oca_lo, wr_oca_hi, wr_ocb_lo, wr_ocb_hi, wr_mask;
	logic rd_lo_any;
	assign wr_cnt_lo = bus_wr && bus_addr == timer16_pkg::COUNTER_OFS; // RL1
	assign wr_cnt_hi = bus_wr && bus_addr == timer16_pkg::COUNTER_OFS + timer16_pkg::HIGH_BYTE_STEP; // RL1
	assign wr_cap_lo = bus_wr && bus_addr == timer16_pkg::CAPTURE_OFS;
	assign wr_cap_hi = bus_wr && bus_addr == timer16_pkg::CAPTURE_OFS + timer16_pkg::HIGH_BYTE_STEP;
	assign wr_oca_lo = bus_wr && bus_addr == timer16_pkg::COMPARE_A_OFS;
	assign wr_oca_hi = bus_wr && bus_addr == timer16_pkg::COMPARE_A_OFS + timer16_pkg::HIGH_BYTE_STEP;
	assign wr_ocb_lo = bus_wr && bus_addr == timer16_pkg::COMPARE_B_OFS;
	assign wr_ocb_hi = bus_wr && bus_addr == timer16_pkg::COMPARE_B_OFS + timer16_pkg::HIGH_BYTE_STEP;
	assign wr_mask   = bus_wr && bus_addr == timer16_pkg::IRQ_MASK_OFS;
	assign rd_lo_any = bus_rd && !bus_wr && (bus_addr == timer16_pkg::COUNTER_OFS
		|| bus_addr == timer16_pkg::CAPTURE_OFS || bus_addr == timer16_pkg::COMPARE_A_OFS
		|| bus_addr == timer16_pkg::COMPARE_B_OFS);

	// Capture source; disconnected when the capture register is TOP so no false events
	assign cap_src   = capture_from_comparator ? comparator_out : capture_input_pin; // RL7
	// No edge is seen until the previous sample is real, so an idle-high pin is no event
	assign cap_event = cap_armed_reg && !capture_is_top && (capture_edge_select
		? (cap_src && !cap_src_prev_reg) : (!cap_src && cap_src_prev_reg)); // RL15 RL16
	// Compare on each tick, except the one following a counter write
	assign match_a = count_tick && !block_match_reg && counter_value_reg == compare_a_value_reg; // RL9 RL5
	assign match_b = count_tick && !block_match_reg && counter_value_reg == compare_b_value_reg; // RL9 RL5
	assign count_next = {1'b0, counter_value_reg} + 17'h00001;

	// Shared high-byte latch: filled by a high write or by a low read
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			temp_reg <= timer16_pkg::TEMP_RESET;
		else if (wr_cnt_hi || wr_cap_hi || wr_oca_hi || wr_ocb_hi)
			temp_reg <= bus_wdata; // RL2 RL3
		else if (rd_lo_any)
		begin
			case (bus_addr)
				timer16_pkg::COUNTER_OFS:   temp_reg <= counter_value_reg[15:8]; // RL3
				timer16_pkg::CAPTURE_OFS:   temp_reg <= capture_value_reg[15:8];
				timer16_pkg::COMPARE_A_OFS: temp_reg <= compare_a_value_reg[15:8];
				default:                    temp_reg <= compare_b_value_reg[15:8];
			endcase
		end
	end

	// Counter: a low-byte write commits latch and data as one 16-bit value
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			counter_value_reg <= timer16_pkg::VALUE_RESET; // RL11
		else if (wr_cnt_lo)
			counter_value_reg <= {temp_reg, bus_wdata}; // RL4 RL3
		else if (count_tick)
			counter_value_reg <= (capture_is_top && counter_value_reg == capture_value_reg)
				? timer16_pkg::VALUE_RESET : count_next[15:0]; // RL8
	end

	// Match blocking lasts until the next timer tick after a counter write
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			block_match_reg <= 1'b0;
		else if (wr_cnt_lo)
			block_match_reg <= 1'b1; // RL5
		else if (count_tick)
			block_match_reg <= 1'b0;
	end

	// Capture register: hardware capture wins over a software write in the same cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			capture_value_reg <= timer16_pkg::VALUE_RESET; // RL11
			cap_src_prev_reg  <= 1'b0;
			cap_armed_reg     <= 1'b0;
		end
		else
		begin
			cap_src_prev_reg <= cap_src;
			cap_armed_reg    <= 1'b1;
			if (cap_event)
				capture_value_reg <= counter_value_reg; // RL7
			else if (wr_cap_lo)
				capture_value_reg <= {temp_reg, bus_wdata};
		end
	end

	// Compare registers, written atomically through the latch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			compare_a_value_reg <= timer16_pkg::VALUE_RESET; // RL11
			compare_b_value_reg <= timer16_pkg::VALUE_RESET;
		end
		else
		begin
			if (wr_oca_lo)
				compare_a_value_reg <= {temp_reg, bus_wdata}; // RL3
			if (wr_ocb_lo)
				compare_b_value_reg <= {temp_reg, bus_wdata};
		end
	end

	// Mask register; only the capture and compare-B bits are held here
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_mask_reg <= timer16_pkg::IRQ_MASK_RESET;
		else if (wr_mask)
			irq_mask_reg <= bus_wdata & timer16_pkg::IRQ_MASK_USED;
	end

	// Flags: a set in the same cycle as a clear wins, so no event is lost
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			capture_flag   <= 1'b0;
			compare_b_flag <= 1'b0;
		end
		else
		begin
			if (cap_event)
				capture_flag <= 1'b1;
			else if (capture_irq_ack || capture_flag_clear)
				capture_flag <= 1'b0; // RL14
			if (match_b)
				compare_b_flag <= 1'b1; // RL10
			else if (compare_b_irq_ack || compare_b_flag_clear)
				compare_b_flag <= 1'b0;
		end
	end

	// Interrupt requests, registered from flag, mask bit and global enable
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			capture_irq   <= 1'b0;
			compare_b_irq <= 1'b0;
		end
		else
		begin
			capture_irq   <= capture_flag && irq_mask_reg[timer16_pkg::CAPTURE_IE_BIT]
				&& global_irq_enable; // RL12
			compare_b_irq <= compare_b_flag && irq_mask_reg[timer16_pkg::COMPARE_B_IE_BIT]
				&& global_irq_enable; // RL13
		end
	end

	// Waveform outputs toggle on match; other waveform modes live elsewhere
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			compare_a_output <= 1'b0;
			compare_b_output <= 1'b0;
			top_value        <= timer16_pkg::VALUE_RESET;
		end
		else
		begin
			if (match_a)
				compare_a_output <= !compare_a_output; // RL10
			if (match_b)
				compare_b_output <= !compare_b_output; // RL10
			top_value <= capture_value_reg; // RL8
		end
	end

	// Read data: high bytes come from the shared latch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			bus_rdata <= timer16_pkg::RDATA_RESET;
		else if (bus_rd)
		begin
			case (bus_addr)
				timer16_pkg::COUNTER_OFS:   bus_rdata <= counter_value_reg[7:0];
				timer16_pkg::CAPTURE_OFS:   bus_rdata <= capture_value_reg[7:0];
				timer16_pkg::COMPARE_A_OFS: bus_rdata <= compare_a_value_reg[7:0];
				timer16_pkg::COMPARE_B_OFS: bus_rdata <= compare_b_value_reg[7:0];
				timer16_pkg::IRQ_MASK_OFS:  bus_rdata <= irq_mask_reg;
				timer16_pkg::COUNTER_OFS + timer16_pkg::HIGH_BYTE_STEP,
				timer16_pkg::CAPTURE_OFS + timer16_pkg::HIGH_BYTE_STEP,
				timer16_pkg::COMPARE_A_OFS + timer16_pkg::HIGH_BYTE_STEP,
				timer16_pkg::COMPARE_B_OFS + timer16_pkg::HIGH_BYTE_STEP:
					bus_rdata <= temp_reg; // RL3
				default:                    bus_rdata <= timer16_pkg::RDATA_RESET;
			endcase
		end
	end

	AST_BLOCK_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
		wr_cnt_lo |=> !match_a && !match_b) else $error("Match after counter write"); // RL5
	AST_CAPTURE_COPY: assert property (@(posedge clk) disable iff (!rst_b)
		cap_event |=> capture_value_reg == $past(counter_value_reg)) else $error("Capture lost"); // RL7
	AST_NO_CAPTURE_TOP: assert property (@(posedge clk) disable iff (!rst_b)
		capture_is_top |-> !cap_event) else $error("Capture while TOP"); // RL15
	AST_CAP_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
		capture_irq |-> $past(irq_mask_reg[timer16_pkg::CAPTURE_IE_BIT] && global_irq_enable))
		else $error("Capture irq ungated"); // RL12
	AST_OCB_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
		compare_b_irq |-> $past(irq_mask_reg[timer16_pkg::COMPARE_B_IE_BIT] && compare_b_flag))
		else $error("Compare B irq ungated"); // RL13
	AST_CAP_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		capture_flag && capture_irq_ack && !cap_event |=> !capture_flag) else $error("Flag kept"); // RL14
	AST_ATOMIC_WR: assert property (@(posedge clk) disable iff (!rst_b)
		wr_cnt_hi ##1 wr_cnt_lo |=> counter_value_reg == {$past(bus_wdata, 2), $past(bus_wdata)})
		else $error("Counter write not atomic"); // RL3
	AST_MATCH_B_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
		match_b |=> compare_b_flag) else $error("Compare B flag not set"); // RL10
	COV_CAPTURE: cover property (@(posedge clk) cap_event);
	COV_MATCH_A: cover property (@(posedge clk) match_a);
	COV_CNT_WR: cover property (@(posedge clk) wr_cnt_hi ##1 wr_cnt_lo);
endmodule
`default_nettype wire

// file: pkg/timer16_pkg.sv
// Package for the 16-bit timer register block: offsets, field positions, reset values.
// Assumes an 8-bit CPU byte bus with addresses at the printed data-space offsets.
`default_nettype none
package timer16_pkg;
	localparam logic [7:0]  IRQ_MASK_OFS     = 8'h6f;
	localparam logic [7:0]  COUNTER_OFS      = 8'ha4;
	localparam logic [7:0]  CAPTURE_OFS      = 8'ha6;
	localparam logic [7:0]  COMPARE_A_OFS    = 8'ha8;
	localparam logic [7:0]  COMPARE_B_OFS    = 8'haa;
	localparam logic [7:0]  HIGH_BYTE_STEP   = 8'h01;
	localparam int          CAPTURE_IE_BIT   = 5;
	localparam int          COMPARE_B_IE_BIT = 2;
	localparam logic [7:0]  IRQ_MASK_USED    = 8'h24;
	localparam logic [7:0]  IRQ_MASK_RESET   = 8'h00;
	localparam logic [15:0] VALUE_RESET      = 16'h0000;
	localparam logic [7:0]  TEMP_RESET       = 8'h00;
	localparam logic [7:0]  RDATA_RESET      = 8'h00;
endpackage
`default_nettype wire

// file: bench/cpu_byte_model.sv
// CPU side model: byte writes and reads on the timer register bus.
// Assumes a shared clk; requests launch 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module cpu_byte_model (
	input  wire logic       clk,
	output logic      [7:0] bus_addr,
	output logic      [7:0] bus_wdata,
	output logic            bus_wr,
	output logic            bus_rd,
	input  wire logic [7:0] bus_rdata
);
	initial
	begin
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	// One-cycle strobe; stale data is inverted so it never looks valid
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(posedge clk);
		#1;
		bus_wr = 1'b0;
		bus_wdata = ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		bus_addr = a;
		bus_rd = 1'b1;
		@(posedge clk);
		#1;
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask
	// High byte first fills the latch, low byte commits all 16 bits; strobe held back to back
	task automatic wr16(input logic [7:0] base, input logic [15:0] v);
		@(posedge clk);
		#1;
		bus_addr = base + 8'h01;
		bus_wdata = v[15:8];
		bus_wr = 1'b1;
		@(posedge clk);
		#1;
		bus_addr = base;
		bus_wdata = v[7:0];
		@(posedge clk);
		#1;
		bus_wr = 1'b0;
		bus_wdata = ~v[7:0];
	endtask
	// Low read first so the high byte comes from the same snapshot
	task automatic rd16(input logic [7:0] base, output logic [15:0] v);
		get(base, v[7:0]);
		get(base + 8'h01, v[15:8]);
	endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the timer register block.
// Assumes the CPU model holds the bus; the bench drives timer-side inputs.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0, tick = 1'b0, pin = 1'b0, esel = 1'b0, istop = 1'b0;
	logic gie = 1'b0, c_ack = 1'b0, b_ack = 1'b0, c_clr = 1'b0, b_clr = 1'b0;
	logic cmp_out = 1'b0, cmp_sel = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, c_flag, b_flag, c_irq, b_irq, out_a, out_b;
	logic [15:0] top, v;
	int err_total = 0, checks_done = 0, cycles = 0;
	always #20 clk = ~clk;
	cpu_byte_model cpu_byte_model_inst (.clk(clk), .bus_addr(addr), .bus_wdata(wdata),
		.bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata));
	timer16_value_regs timer16_value_regs_inst (.clk(clk), .rst_b(rst_b), .bus_addr(addr),
		.bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata), .count_tick(tick),
		.capture_input_pin(pin), .comparator_out(cmp_out), .capture_from_comparator(cmp_sel),
		.capture_edge_select(esel), .capture_is_top(istop), .global_irq_enable(gie),
		.capture_irq_ack(c_ack), .compare_b_irq_ack(b_ack), .capture_flag_clear(c_clr),
		.compare_b_flag_clear(b_clr), .capture_flag(c_flag), .compare_b_flag(b_flag),
		.capture_irq(c_irq), .compare_b_irq(b_irq), .compare_a_output(out_a),
		.compare_b_output(out_b), .top_value(top));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Pulse an input for one cycle; the counter only moves on tick
	task automatic pulse(ref logic s);
		@(posedge clk);
		#1;
		s = 1'b1;
		@(posedge clk);
		#1;
		s = 1'b0;
	endtask
	task automatic reset_values();
		for (int i = 0; i < 4; i++)
		begin
			cpu_byte_model_inst.rd16(8'ha4 + 8'(2 * i), v);
			chk("reg", 16'h0000, v);
		end
		cpu_byte_model_inst.get(8'h50, v[7:0]);
		chk("unmapped", 16'h0000, {8'h00, v[7:0]});
	endtask
	task automatic shared_latch();
		cpu_byte_model_inst.put(8'ha9, 8'h5a);
		cpu_byte_model_inst.put(8'haa, 8'h01);
		cpu_byte_model_inst.rd16(8'haa, v);
		chk("cmp_b", 16'h5a01, v);
		cpu_byte_model_inst.put(8'h6f, 8'hff);
		cpu_byte_model_inst.get(8'h6f, v[7:0]);
		chk("mask", 16'h0024, {8'h00, v[7:0]});
	endtask
	// Writing the match value then ticking must not match; stopped counter while writing
	task automatic compare_match();
		gie = 1'b1;
		cpu_byte_model_inst.wr16(8'ha8, 16'h0105);
		cpu_byte_model_inst.wr16(8'haa, 16'h0105);
		cpu_byte_model_inst.wr16(8'ha4, 16'h0105);
		pulse(tick);
		repeat (2) @(posedge clk);
		#1;
		chk("blocked", 16'h0000, {b_flag, out_a, out_b});
		cpu_byte_model_inst.wr16(8'ha4, 16'h0104);
		pulse(tick);
		pulse(tick);
		repeat (2) @(posedge clk);
		#1;
		chk("match", 16'h000f, {b_flag, b_irq, out_a, out_b});
		pulse(b_ack);
		repeat (2) @(posedge clk);
		#1;
		chk("b_ack", 16'h0000, {b_flag, b_irq});
		cpu_byte_model_inst.rd16(8'ha4, v);
		chk("count", 16'h0106, v);
		// Second match at the new count, cleared by a write-one instead of service
		cpu_byte_model_inst.wr16(8'haa, 16'h0106);
		pulse(tick);
		chk("b_set", 16'h0001, {15'h0000, b_flag});
		pulse(b_clr);
		repeat (2) @(posedge clk);
		#1;
		chk("b_clr", 16'h0000, {b_flag, b_irq});
	endtask
	task automatic capture();
		for (int e = 1; e >= 0; e--)
		begin
			cpu_byte_model_inst.wr16(8'ha4, 16'h1230 + 16'(e));
			esel = e[0];
			pin = ~e[0];
			repeat (3) @(posedge clk);
			#1;
			pin = e[0];
			repeat (3) @(posedge clk);
			#1;
			chk("cap_irq", 16'h0003, {c_flag, c_irq});
			cpu_byte_model_inst.rd16(8'ha6, v);
			chk("cap", 16'h1230 + 16'(e), v);
			if (e == 1)
				pulse(c_ack);
			else
				pulse(c_clr);
			repeat (2) @(posedge clk);
			#1;
			chk("cap_clr", 16'h0000, {c_flag, c_irq});
		end
		chk("top", 16'h1230, top);
		// Comparator as source: its rising output captures like the pin
		cmp_sel = 1'b1;
		esel = 1'b1;
		cpu_byte_model_inst.wr16(8'ha4, 16'h4321);
		cmp_out = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("cmp_flag", 16'h0001, {15'h0000, c_flag});
		cpu_byte_model_inst.rd16(8'ha6, v);
		chk("cmp_cap", 16'h4321, v);
		pulse(c_clr);
		cmp_sel = 1'b0;
		// Capture as TOP: pin edges ignored, counter wraps to zero after TOP
		istop = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		pin = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("cap_off", 16'h0000, {c_flag});
		cpu_byte_model_inst.wr16(8'ha4, 16'h4321);
		pulse(tick);
		cpu_byte_model_inst.rd16(8'ha4, v);
		chk("wrap", 16'h0000, v);
	endtask
	// Cut a hang short after far more cycles than the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			results();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		#1;
		rst_b = 1'b1;
		reset_values();
		shared_latch();
		compare_match();
		capture();
		results();
	end
endmodule
`default_nettype wire
